// >>> hdl/plcs_pkg.sv
// package for the link control and status register pair
package plcs_pkg;
    localparam logic [7:0] PLCS_OFF_CTRL = 8'hA0;
    localparam logic [7:0] PLCS_OFF_STAT = 8'hA2;
    localparam logic [15:0] PLCS_CTRL_RST = 16'h0000;
    localparam logic [15:0] PLCS_CTRL_WMASK = 16'h01CB;
    localparam int PLCS_B_CPM = 8;
    localparam int PLCS_B_ES = 7;
    localparam int PLCS_B_CCC = 6;
    localparam int PLCS_B_RCB = 3;
    localparam int PLCS_B_ASPM_HI = 1;
    localparam int PLCS_B_ASPM_LO = 0;
    localparam int PLCS_B_SCC = 12;
    localparam logic [5:0] PLCS_WIDTH_X1 = 6'h01;
    localparam logic [3:0] PLCS_SPEED_GEN1 = 4'h1;
    localparam logic [1:0] PLCS_ASPM_L0S = 2'h1;
    localparam logic [1:0] PLCS_ASPM_L1 = 2'h2;
    // exit latency codes, common and separate clocking
    localparam logic [2:0] PLCS_L0S_LAT_COMMON = 3'h3;
    localparam logic [2:0] PLCS_L0S_LAT_ASYNC = 3'h4;
    localparam logic [15:0] PLCS_ZERO16 = 16'h0000;
    // the device's own completion boundary, fixed whatever the hint holds
    localparam logic [7:0] PLCS_OWN_RCB_BYTES = 8'h80;

    // configuration access carried as one bundle
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [1:0] be;
        logic [15:0] wdata;
    } plcs_cfg_s;

    typedef struct packed {
        logic clock_pm_enable;
        logic extended_sync;
        logic common_clock;
        logic completion_boundary_hint;
        logic [1:0] active_state_pm_control;
    } plcs_ctrl_s;
endpackage : plcs_pkg

// >>> hdl/plcs_status_word.sv
// link status word composer
`timescale 1ns/1ps
module plcs_status_word
    import plcs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic slot_clock_strap,
    output logic [15:0] status_word
);
    logic slot_clock_flag_r;

    // strap caught by the clock after reset, never by the reset itself
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            slot_clock_flag_r <= 1'b0;
        else
            slot_clock_flag_r <= slot_clock_strap;
    end

    // width x1, speed 2.5 Gb/s, training and retrain bits zero
    always_comb
    begin
        status_word = PLCS_ZERO16;
        status_word[PLCS_B_SCC] = slot_clock_flag_r;
        status_word[9:4] = PLCS_WIDTH_X1;
        status_word[3:0] = PLCS_SPEED_GEN1;
    end
endmodule : plcs_status_word

// >>> hdl/plcs_link_regs.sv
// link control and status configuration registers
`timescale 1ns/1ps
// Functional notes
// - clock pm enable clear: clkreq request held low always
// - clock pm enable set: clkreq may be released to stop reference
// - extended sync set: longer fts run plus extra ts2 on l1 exit
// - common clock flag writable and selects reported exit latencies
// - retrain and link disable bits do nothing and read zero
// - completion boundary hint is storage only; own boundary 128 bytes
// - two-bit field enables l0s and/or l1 entry
// - control bits 15:9 and bit 2 read zero
// - control word at a0h, resets to zero
// - status word at a2h, read only, bits 4 and 0 set
// - status bit 12 shows common 100 mhz reference clocking
// - status width x1, speed code 1h, training bit zero
module plcs_link_regs
    import plcs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input plcs_cfg_s cfg,
    output logic [15:0] cfg_rdata,
    output logic cfg_hit,
    input wire logic slot_clock_strap,
    input wire logic link_idle_req,
    output logic clkreq_n_out,
    output plcs_ctrl_s ctrl,
    output logic l0s_entry_en,
    output logic l1_entry_en,
    output logic [2:0] l0s_exit_latency,
    output logic [2:0] l1_exit_latency,
    output logic extended_fts,
    output logic extra_ts2,
    output logic [7:0] own_rcb_bytes
);
    logic [15:0] ctrl_r;
    logic [15:0] ctrl_nxt;
    logic [15:0] status_word;
    logic [15:0] rdata_r;
    logic clkreq_rel_r;

    // shared address decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    plcs_status_word plcs_status_word_i (
        .clk_sys(clk_sys),
        .srst(srst),
        .slot_clock_strap(slot_clock_strap),
        .status_word(status_word)
    );

    // masked byte-lane write; fixed bits never take write data
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        if (cfg.wr && hit(cfg.addr, PLCS_OFF_CTRL))
        begin
            if (cfg.be[0])
                ctrl_nxt[7:0] = cfg.wdata[7:0] & PLCS_CTRL_WMASK[7:0];
            if (cfg.be[1])
                ctrl_nxt[15:8] = cfg.wdata[15:8] & PLCS_CTRL_WMASK[15:8];
        end
    end

    // control word storage
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            ctrl_r <= PLCS_CTRL_RST;
        else
            ctrl_r <= ctrl_nxt;
    end

    // registered read data; unmapped offsets read zero
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            rdata_r <= PLCS_ZERO16;
        else if (cfg.rd && hit(cfg.addr, PLCS_OFF_CTRL))
            rdata_r <= ctrl_r;
        else if (cfg.rd && hit(cfg.addr, PLCS_OFF_STAT))
            rdata_r <= status_word;
        else if (cfg.rd)
            rdata_r <= PLCS_ZERO16;
    end
    assign cfg_rdata = rdata_r;
    assign cfg_hit = hit(cfg.addr, PLCS_OFF_CTRL) || hit(cfg.addr, PLCS_OFF_STAT);

    // clkreq release only while enabled and the link asks to idle
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            clkreq_rel_r <= 1'b0;
        else
            clkreq_rel_r <= ctrl_r[PLCS_B_CPM] && link_idle_req;
    end
    // gated again by the live bit so a clear drops release at once
    assign clkreq_n_out = clkreq_rel_r && ctrl_r[PLCS_B_CPM];

    // field breakout
    assign ctrl.clock_pm_enable = ctrl_r[PLCS_B_CPM];
    assign ctrl.extended_sync = ctrl_r[PLCS_B_ES];
    assign ctrl.common_clock = ctrl_r[PLCS_B_CCC];
    assign ctrl.completion_boundary_hint = ctrl_r[PLCS_B_RCB];
    assign ctrl.active_state_pm_control = ctrl_r[PLCS_B_ASPM_HI:PLCS_B_ASPM_LO];

    assign l0s_entry_en = ctrl_r[PLCS_B_ASPM_LO];
    assign l1_entry_en = ctrl_r[PLCS_B_ASPM_HI];
    assign extended_fts = ctrl_r[PLCS_B_ES];
    assign extra_ts2 = ctrl_r[PLCS_B_ES];
    // hint never changes the device's own boundary
    assign own_rcb_bytes = PLCS_OWN_RCB_BYTES;

    // latency choice follows the common clock flag
    assign l0s_exit_latency = ctrl_r[PLCS_B_CCC] ? PLCS_L0S_LAT_COMMON
                                                 : PLCS_L0S_LAT_ASYNC;
    assign l1_exit_latency = ctrl_r[PLCS_B_CCC] ? PLCS_L0S_LAT_COMMON
                                                : PLCS_L0S_LAT_ASYNC;

    property p_clkreq_low;
        @(posedge clk_sys) disable iff (srst)
        !ctrl_r[PLCS_B_CPM] |-> !clkreq_n_out;
    endproperty
    a_clkreq_low: assert property (p_clkreq_low) else $error("clkreq released while disabled");

    property p_rsvd_zero;
        @(posedge clk_sys) disable iff (srst)
        (ctrl_r & ~PLCS_CTRL_WMASK) == PLCS_ZERO16;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("fixed control bit nonzero");

    property p_write_takes;
        @(posedge clk_sys) disable iff (srst)
        (cfg.wr && cfg.addr == PLCS_OFF_CTRL && cfg.be == 2'h3)
            |=> ctrl_r == ($past(cfg.wdata) & PLCS_CTRL_WMASK);
    endproperty
    a_write_takes: assert property (p_write_takes) else $error("control write lost");

    property p_stat_read;
        @(posedge clk_sys) disable iff (srst)
        (cfg.rd && cfg.addr == PLCS_OFF_STAT) |=> cfg_rdata[11:0] == 12'h011;
    endproperty
    a_stat_read: assert property (p_stat_read) else $error("status read wrong");

    property p_latency;
        @(posedge clk_sys) disable iff (srst)
        ctrl_r[PLCS_B_CCC] |-> l0s_exit_latency == PLCS_L0S_LAT_COMMON;
    endproperty
    a_latency: assert property (p_latency) else $error("latency not following flag");

    property p_aspm;
        @(posedge clk_sys) disable iff (srst)
        {l1_entry_en, l0s_entry_en} == ctrl.active_state_pm_control;
    endproperty
    a_aspm: assert property (p_aspm) else $error("aspm enables mismatch");

    property p_es;
        @(posedge clk_sys) disable iff (srst)
        $rose(ctrl_r[PLCS_B_ES]) |-> extended_fts && extra_ts2;
    endproperty
    a_es: assert property (p_es) else $error("extended sync not driven");

    property p_reset_zero;
        @(posedge clk_sys)
        srst |=> ctrl_r == PLCS_CTRL_RST;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("control not reset");

    // release must trace back to an idle request one cycle earlier
    property p_clkreq_idle;
        @(posedge clk_sys) disable iff (srst)
        clkreq_n_out |-> $past(link_idle_req);
    endproperty
    a_clkreq_idle: assert property (p_clkreq_idle) else $error("clkreq released without idle");

    // clearing the enable must pull the request low in the very next cycle
    property p_cpm_write;
        @(posedge clk_sys) disable iff (srst)
        (cfg.wr && cfg.addr == PLCS_OFF_CTRL && cfg.be[1] && !cfg.wdata[PLCS_B_CPM])
            |=> !clkreq_n_out;
    endproperty
    a_cpm_write: assert property (p_cpm_write) else $error("clkreq not held after clear");

    // read data returns the stored word, so fixed bits read zero too
    property p_rdata_ctrl;
        @(posedge clk_sys) disable iff (srst)
        (cfg.rd && cfg.addr == PLCS_OFF_CTRL) |=> cfg_rdata == $past(ctrl_r);
    endproperty
    a_rdata_ctrl: assert property (p_rdata_ctrl) else $error("control read wrong");

    // the hint is plain storage of the written bit
    property p_hint_store;
        @(posedge clk_sys) disable iff (srst)
        (cfg.wr && cfg.addr == PLCS_OFF_CTRL && cfg.be[0])
            |=> ctrl.completion_boundary_hint == $past(cfg.wdata[PLCS_B_RCB]);
    endproperty
    a_hint_store: assert property (p_hint_store) else $error("boundary hint not stored");

    property p_l1_latency;
        @(posedge clk_sys) disable iff (srst)
        !ctrl_r[PLCS_B_CCC] |-> l1_exit_latency == PLCS_L0S_LAT_ASYNC;
    endproperty
    a_l1_latency: assert property (p_l1_latency) else $error("l1 latency not following flag");

    // status fields other than the clocking bit never move
    property p_status_fixed;
        @(posedge clk_sys) disable iff (srst)
        status_word[9:4] == PLCS_WIDTH_X1 && status_word[3:0] == PLCS_SPEED_GEN1
            && status_word[11:10] == 2'h0 && status_word[15:13] == 3'h0;
    endproperty
    a_status_fixed: assert property (p_status_fixed) else $error("status fixed field wrong");

    // one flop of lag; the cycle after reset still shows the cleared flag
    property p_scc_follow;
        @(posedge clk_sys) disable iff (srst)
        !$past(srst)
            |-> status_word[PLCS_B_SCC] == $past(slot_clock_strap);
    endproperty
    a_scc_follow: assert property (p_scc_follow) else $error("clock flag not following strap");

    // only a control write may move the stored word
    property p_ctrl_hold;
        @(posedge clk_sys) disable iff (srst)
        !(cfg.wr && cfg.addr == PLCS_OFF_CTRL)
            |=> ctrl_r == $past(ctrl_r);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed without write");
endmodule : plcs_link_regs

// >>> tb/plcs_partner.sv
// link partner model: reference clock strap and idle request
`timescale 1ns/1ps
module plcs_partner
    import plcs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic common_ref,
    input wire logic want_idle,
    output logic slot_clock_strap,
    output logic link_idle_req
);
    // levels change only after an edge, as a board strap or a far end would
    always_ff @(posedge clk_sys)
    begin
        slot_clock_strap <= common_ref;
        link_idle_req <= want_idle;
    end
endmodule : plcs_partner

// >>> tb/plcs_link_regs_tb.sv
// self-checking bench for the link control and status pair
`timescale 1ns/1ps
module plcs_link_regs_tb;
    import plcs_pkg::*;
    logic clk_sys = 0;
    logic srst = 1;
    logic common_ref = 1;
    logic want_idle = 1;
    logic rd_d = 0;
    logic slot_clock_strap, link_idle_req, cfg_hit, clkreq_n_out;
    logic l0s_entry_en, l1_entry_en, extended_fts, extra_ts2;
    logic [2:0] l0s_exit_latency, l1_exit_latency;
    logic [7:0] own_rcb_bytes;
    logic [15:0] cfg_rdata, wd;
    logic [15:0] exp_q[$];
    plcs_cfg_s cfg = '0;
    plcs_ctrl_s ctrl;
    int fail_count = 0;
    int n_compared = 0;
    int seed = 32'hab6a;
    plcs_partner plcs_partner_i (.clk_sys(clk_sys), .common_ref(common_ref),
        .want_idle(want_idle), .slot_clock_strap(slot_clock_strap),
        .link_idle_req(link_idle_req));
    plcs_link_regs plcs_link_regs_i (.clk_sys(clk_sys), .srst(srst), .cfg(cfg),
        .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit), .slot_clock_strap(slot_clock_strap),
        .link_idle_req(link_idle_req), .clkreq_n_out(clkreq_n_out), .ctrl(ctrl),
        .l0s_entry_en(l0s_entry_en), .l1_entry_en(l1_entry_en),
        .l0s_exit_latency(l0s_exit_latency), .l1_exit_latency(l1_exit_latency),
        .extended_fts(extended_fts), .extra_ts2(extra_ts2), .own_rcb_bytes(own_rcb_bytes));
    always #12.5 clk_sys = ~clk_sys;
    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict
    // one request per task, dropped one cycle later so strobes never merge
    task wr(input logic [7:0] a, input logic [1:0] bsel, input logic [15:0] d);
        @(posedge clk_sys);
        #1 cfg = '{rd:1'b0, wr:1'b1, addr:a, be:bsel, wdata:d};
        @(posedge clk_sys);
        #1 cfg.wr = 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        #1 cfg = '{rd:1'b1, wr:1'b0, addr:a, be:2'h3, wdata:16'h0000};
        exp_q.push_back(e);
        @(posedge clk_sys);
        #1 cfg.rd = 1'b0;
    endtask : rd
    // scoreboard: read data is due the cycle after the read is taken
    always @(posedge clk_sys)
    begin
        if (rd_d && exp_q.size() > 0)
            chk("cfg_rdata", cfg_rdata, exp_q.pop_front());
        rd_d <= cfg.rd;
    end
    // hang guard: well above the length of the main sequence
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        fail_count++;
        print_verdict();
    end
    initial
    begin
        repeat (10) @(posedge clk_sys);
        #1 srst = 0;
        rd(PLCS_OFF_CTRL, PLCS_CTRL_RST);
        rd(PLCS_OFF_STAT, 16'h1011);
        chk("clkreq", 16'(clkreq_n_out), 16'h0000);
        $display("test reset done");
        wr(PLCS_OFF_CTRL, 2'h3, 16'hFFFF);
        rd(PLCS_OFF_CTRL, PLCS_CTRL_WMASK);
        chk("latency", 16'({l0s_exit_latency, l1_exit_latency}), 16'h001B);
        chk("own_rcb", 16'(own_rcb_bytes), 16'h0080);
        chk("sync", 16'({extended_fts, extra_ts2}), 16'h0003);
        chk("clkreq", 16'(clkreq_n_out), 16'h0001);
        // no idle request from the far end: request must drop low again
        want_idle = 0;
        repeat (2) @(posedge clk_sys);
        #1 chk("clkreq", 16'(clkreq_n_out), 16'h0000);
        want_idle = 1;
        wr(PLCS_OFF_CTRL, 2'h2, 16'h0000);
        chk("clkreq", 16'(clkreq_n_out), 16'h0000);
        rd(PLCS_OFF_CTRL, 16'h00CB);
        $display("test control done");
        wr(PLCS_OFF_STAT, 2'h3, 16'hFFFF);
        common_ref = 0;
        repeat (3) @(posedge clk_sys);
        rd(PLCS_OFF_STAT, 16'h0011);
        chk("hit", 16'(cfg_hit), 16'h0001);
        $display("test status done");
        // every power-state code, random bits elsewhere must be masked
        for (int i = 0; i < 4; i++)
        begin
            wd = 16'($random(seed));
            wd[1:0] = i[1:0];
            wr(PLCS_OFF_CTRL, 2'h3, wd);
            rd(PLCS_OFF_CTRL, wd & PLCS_CTRL_WMASK);
            chk("aspm", 16'({l1_entry_en, l0s_entry_en}), 16'(i[1:0]));
            chk("l0s_lat", 16'(l0s_exit_latency), wd[6] ? 16'h0003 : 16'h0004);
            chk("ctrl", 16'(ctrl), 16'({wd[8], wd[7], wd[6], wd[3], wd[1:0]}));
        end
        rd(8'hA4, 16'h0000);
        chk("hit", 16'(cfg_hit), 16'h0000);
        $display("test modes done");
        // reset in mid-run must clear every writable bit again
        wr(PLCS_OFF_CTRL, 2'h3, 16'hFFFF);
        @(posedge clk_sys);
        #1 srst = 1;
        repeat (2) @(posedge clk_sys);
        #1 srst = 0;
        chk("clkreq", 16'(clkreq_n_out), 16'h0000);
        rd(PLCS_OFF_CTRL, PLCS_CTRL_RST);
        $display("test second reset done");
        repeat (2) @(posedge clk_sys);
        print_verdict();
    end
endmodule : plcs_link_regs_tb
